// file: design/burst_align_pkg.sv
// Purpose : shared constants and types for the unaligned read burst expander
// Assumes : one clock, asynchronous active-high reset
// Notes   : widths are module parameters; these are their defaults and limits
package burst_align_pkg;

  // ------------------------------------------------------------------
  // parameter defaults and legal limits
  // ------------------------------------------------------------------
  localparam int DEF_DATA_W   = 32;     // narrow master word
  localparam int DEF_ADDR_W   = 24;     // word-granular master address
  localparam int DEF_BURST_W  = 4;      // master burst count width
  localparam int DEF_MAX_PEND = 16;     // outstanding read commands
  localparam int DEF_SLAVE_W  = 64;     // wide slave word
  localparam bit DEF_PIPE_CMD = 1'b0;   // extra command register stage
  localparam int PEND_LIMIT   = 64;     // deepest pending queue allowed
  localparam int SLAVE_W_MIN  = 16;
  localparam int SLAVE_W_MAX  = 4096;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic WAIT_RST  = 1'b1;    // master held off during reset
  localparam logic READ_RST  = 1'b0;
  localparam logic VALID_RST = 1'b0;

  // command path states, one-hot
  typedef enum logic [2:0] {
    CMD_IDLE   = 3'b001,
    CMD_STAGED = 3'b010,
    CMD_ISSUE  = 3'b100
  } cmd_state_e;

  // true for a nonzero power of two
  function automatic bit is_pow2(input int v);
    return (v > 0) && ((v & (v - 1)) == 0);
  endfunction

endpackage

// file: design/pending_cmd_if.sv
// Purpose : carries issued-command records between the bridge and its queue
// Assumes : one clock domain
// Notes   : head fields are valid only while empty is low
`timescale 1ns/1ps
interface pending_cmd_if #(
  parameter int LEAD_W = 1,
  parameter int LEN_W  = 4,
  parameter int EXP_W  = 5,
  parameter int CNT_W  = 5
);
  logic              push;
  logic [LEAD_W-1:0] push_lead;
  logic [LEN_W-1:0]  push_len;
  logic [EXP_W-1:0]  push_exp;
  logic              pop;
  logic [LEAD_W-1:0] head_lead;
  logic [LEN_W-1:0]  head_len;
  logic [EXP_W-1:0]  head_exp;
  logic              empty;
  logic [CNT_W-1:0]  count;

  modport client (output push, push_lead, push_len, push_exp, pop,
                  input  head_lead, head_len, head_exp, empty, count);
  modport store  (input  push, push_lead, push_len, push_exp, pop,
                  output head_lead, head_len, head_exp, empty, count);
endinterface // pending_cmd_if

// file: design/pending_cmd_queue.sv
// Purpose : in-order store of records for read commands sent downstream
// Assumes : caller never pushes when full nor pops when empty
// Notes   : records leave in issue order, so responses never reorder
`timescale 1ns/1ps
module pending_cmd_queue #(
  parameter int DEPTH  = 16,
  parameter int LEAD_W = 1,
  parameter int LEN_W  = 4,
  parameter int EXP_W  = 5,
  parameter int CNT_W  = 5
) (
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  pending_cmd_if.store   q
);
  import burst_align_pkg::*;

  localparam int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int REC_W = LEAD_W + LEN_W + EXP_W;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [REC_W-1:0] rec_mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;

  // wrap a pointer without requiring a power-of-two depth
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    return (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  // ------------------------------------------------------------------
  // pointer and occupancy bookkeeping
  // ------------------------------------------------------------------
  always_comb begin
    wr_ptr_nxt = q.push ? ptr_step(wr_ptr_r) : wr_ptr_r;
    rd_ptr_nxt = q.pop  ? ptr_step(rd_ptr_r) : rd_ptr_r;
    count_nxt  = count_r;
    if (q.push && !q.pop) begin
      count_nxt = CNT_W'(count_r + 1'b1);
    end else if (q.pop && !q.push) begin
      count_nxt = CNT_W'(count_r - 1'b1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // record storage has no reset; entries are read only after a push
  always_ff @(posedge clk_in) begin
    if (q.push) begin
      rec_mem[wr_ptr_r] <= {q.push_lead, q.push_len, q.push_exp};
    end
  end

  assign {q.head_lead, q.head_len, q.head_exp} = rec_mem[rd_ptr_r];
  assign q.empty = (count_r == '0);
  assign q.count = count_r;

  // occupancy never passes the configured depth
  a_queue_depth: assert property (@(posedge clk_in) disable iff (rst_in)
    count_r <= CNT_W'(DEPTH))
    else $error("pending queue holds more records than its depth");

endmodule // pending_cmd_queue

// file: design/unaligned_read_burst_expander.sv
// Purpose : widens unaligned narrow read bursts to whole slave words
// Assumes : downstream slaves answer reads in order, one narrow word per beat
// Notes   : addresses and burst counts on both sides count narrow words
//
// Local design decisions: the plain strobed port.
`timescale 1ns/1ps
module unaligned_read_burst_expander #(
  parameter int DATA_W   = burst_align_pkg::DEF_DATA_W,
  parameter int ADDR_W   = burst_align_pkg::DEF_ADDR_W,
  parameter int BURST_W  = burst_align_pkg::DEF_BURST_W,
  parameter int MAX_PEND = burst_align_pkg::DEF_MAX_PEND,
  parameter int SLAVE_W  = burst_align_pkg::DEF_SLAVE_W,
  parameter bit PIPE_CMD = burst_align_pkg::DEF_PIPE_CMD,
  localparam int LEAD_W  = $clog2(SLAVE_W / DATA_W),
  localparam int EXP_W   = BURST_W + LEAD_W
) (
  input  wire logic               CLK_IN,
  input  wire logic               RST_IN,
  // upstream, facing the narrow master
  input  wire logic [ADDR_W-1:0]  US_ADDR_IN,
  input  wire logic [BURST_W-1:0] US_BURST_IN,
  input  wire logic               US_READ_IN,
  output logic                    US_WAIT_OUT,
  output logic [DATA_W-1:0]       US_RDATA_OUT,
  output logic                    US_RVALID_OUT,
  // downstream, facing the wide slaves
  output logic [ADDR_W-1:0]       DS_ADDR_OUT,
  output logic [EXP_W-1:0]        DS_BURST_OUT,
  output logic                    DS_READ_OUT,
  input  wire logic               DS_WAIT_IN,
  input  wire logic [DATA_W-1:0]  DS_RDATA_IN,
  input  wire logic               DS_RVALID_IN
);
  import burst_align_pkg::*;

  localparam int RATIO = SLAVE_W / DATA_W;
  localparam int CNT_W = $clog2(MAX_PEND + 1);
  localparam logic [ADDR_W-1:0] ADDR_MASK = ~ADDR_W'(RATIO - 1);
  localparam logic [EXP_W-1:0]  LEN_MASK  = ~EXP_W'(RATIO - 1);
  localparam logic [EXP_W-1:0]  LEN_ROUND = EXP_W'(RATIO - 1);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (!is_pow2(SLAVE_W) || SLAVE_W < SLAVE_W_MIN || SLAVE_W > SLAVE_W_MAX) begin : g_bad_sw
    $error("slave width must be a power of two in the supported range");
  end
  if (!is_pow2(DATA_W) || SLAVE_W < 2 * DATA_W) begin : g_bad_dw
    $error("master width must be a power of two below the slave width");
  end
  if (MAX_PEND < 1 || MAX_PEND > PEND_LIMIT) begin : g_bad_pend
    $error("pending read depth out of range");
  end
  if (BURST_W < 1 || ADDR_W <= LEAD_W) begin : g_bad_aw
    $error("address or burst width too small");
  end

  // end of the request rounded up to a whole slave word, in narrow words
  function automatic logic [EXP_W-1:0] expand_len(input logic [LEAD_W-1:0]  lead,
                                                  input logic [BURST_W-1:0] len);
    logic [EXP_W-1:0] span;
    span = EXP_W'(lead) + EXP_W'(len);
    return EXP_W'(span + LEN_ROUND) & LEN_MASK;
  endfunction

  pending_cmd_if #(
    .LEAD_W (LEAD_W),
    .LEN_W  (BURST_W),
    .EXP_W  (EXP_W),
    .CNT_W  (CNT_W)
  ) q ();

  pending_cmd_queue #(
    .DEPTH  (MAX_PEND),
    .LEAD_W (LEAD_W),
    .LEN_W  (BURST_W),
    .EXP_W  (EXP_W),
    .CNT_W  (CNT_W)
  ) u_queue (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .q      (q.store)
  );

  // ------------------------------------------------------------------
  // command path
  // ------------------------------------------------------------------
  cmd_state_e         state_r, state_nxt;
  logic [ADDR_W-1:0]  raw_addr_r, raw_addr_nxt;
  logic [BURST_W-1:0] raw_len_r, raw_len_nxt;
  logic [ADDR_W-1:0]  ds_addr_r, ds_addr_nxt;
  logic [EXP_W-1:0]   ds_len_r, ds_len_nxt;
  logic               ds_read_r, ds_read_nxt;
  logic [LEAD_W-1:0]  rec_lead_r, rec_lead_nxt;
  logic [BURST_W-1:0] rec_len_r, rec_len_nxt;
  logic               wait_r, wait_nxt;
  logic               accept;
  logic               issue_done;
  logic [ADDR_W-1:0]  ld_addr;
  logic [BURST_W-1:0] ld_len;
  logic [CNT_W:0]     fill_nxt;

  assign accept     = US_READ_IN && !wait_r;
  assign issue_done = ds_read_r && !DS_WAIT_IN;

  // one command in flight in the path; the master waits while it is busy
  always_comb begin
    state_nxt    = state_r;
    raw_addr_nxt = raw_addr_r;
    raw_len_nxt  = raw_len_r;
    ds_addr_nxt  = ds_addr_r;
    ds_len_nxt   = ds_len_r;
    ds_read_nxt  = ds_read_r;
    rec_lead_nxt = rec_lead_r;
    rec_len_nxt  = rec_len_r;
    ld_addr      = PIPE_CMD ? raw_addr_r : US_ADDR_IN;
    ld_len       = PIPE_CMD ? raw_len_r : US_BURST_IN;
    case (state_r)
      CMD_IDLE: begin
        if (accept && PIPE_CMD) begin
          raw_addr_nxt = US_ADDR_IN;
          raw_len_nxt  = US_BURST_IN;
          state_nxt    = CMD_STAGED;
        end else if (accept) begin
          state_nxt    = CMD_ISSUE;
        end
      end
      CMD_STAGED: begin
        state_nxt = CMD_ISSUE;
      end
      CMD_ISSUE: begin
        if (issue_done) begin
          ds_read_nxt = 1'b0;
          state_nxt   = CMD_IDLE;
        end
      end
      default: begin
        state_nxt = CMD_IDLE;
      end
    endcase
    // load the aligned command when the address enters the issue state
    if (state_nxt == CMD_ISSUE && state_r != CMD_ISSUE) begin
      ds_addr_nxt  = ld_addr & ADDR_MASK;
      rec_lead_nxt = ld_addr[LEAD_W-1:0];
      rec_len_nxt  = ld_len;
      ds_len_nxt   = expand_len(ld_addr[LEAD_W-1:0], ld_len);
      ds_read_nxt  = 1'b1;
    end
    // occupancy after this edge; keeps a slot free for the next accept
    fill_nxt = (CNT_W + 1)'(q.count) + (CNT_W + 1)'(q.push) - (CNT_W + 1)'(q.pop);
    wait_nxt = (state_nxt != CMD_IDLE) || (fill_nxt >= (CNT_W + 1)'(MAX_PEND));
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r    <= CMD_IDLE;
      raw_addr_r <= '0;
      raw_len_r  <= '0;
      ds_addr_r  <= '0;
      ds_len_r   <= '0;
      ds_read_r  <= READ_RST;
      rec_lead_r <= '0;
      rec_len_r  <= '0;
      wait_r     <= WAIT_RST;
    end else begin
      state_r    <= state_nxt;
      raw_addr_r <= raw_addr_nxt;
      raw_len_r  <= raw_len_nxt;
      ds_addr_r  <= ds_addr_nxt;
      ds_len_r   <= ds_len_nxt;
      ds_read_r  <= ds_read_nxt;
      rec_lead_r <= rec_lead_nxt;
      rec_len_r  <= rec_len_nxt;
      wait_r     <= wait_nxt;
    end
  end

  // record the original request the moment the slave takes the command
  assign q.push      = issue_done;
  assign q.push_lead = rec_lead_r;
  assign q.push_len  = rec_len_r;
  assign q.push_exp  = ds_len_r;

  // ------------------------------------------------------------------
  // response path
  // ------------------------------------------------------------------
  logic [EXP_W-1:0]  beat_r, beat_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic              beat_ok;
  logic              keep;
  logic              last_beat;

  // a beat with no record behind it cannot occur with in-order slaves
  always_comb begin
    beat_ok    = DS_RVALID_IN && !q.empty;
    keep       = (beat_r >= EXP_W'(q.head_lead)) &&
                 (beat_r < EXP_W'(EXP_W'(q.head_lead) + EXP_W'(q.head_len)));
    last_beat  = beat_ok && (beat_r == EXP_W'(q.head_exp - 1'b1));
    beat_nxt   = beat_r;
    if (last_beat) begin
      beat_nxt = '0;
    end else if (beat_ok) begin
      beat_nxt = EXP_W'(beat_r + 1'b1);
    end
    rvalid_nxt = beat_ok && keep;
    rdata_nxt  = DS_RVALID_IN ? DS_RDATA_IN : rdata_r;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      beat_r   <= '0;
      rdata_r  <= '0;
      rvalid_r <= VALID_RST;
    end else begin
      beat_r   <= beat_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // the oldest record retires with its final beat
  assign q.pop = last_beat;

  assign US_WAIT_OUT   = wait_r;
  assign US_RDATA_OUT  = rdata_r;
  assign US_RVALID_OUT = rvalid_r;
  assign DS_ADDR_OUT   = ds_addr_r;
  assign DS_BURST_OUT  = ds_len_r;
  assign DS_READ_OUT   = ds_read_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  logic [ADDR_W-1:0]  acc_addr_h;
  logic [BURST_W-1:0] acc_len_h;
  logic [BURST_W:0]   sent_h;
  logic [EXP_W-1:0]   acc_span_h;

  // watcher copy of the last accepted request and words sent per command
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      acc_addr_h <= '0;
      acc_len_h  <= '0;
      sent_h     <= '0;
    end else begin
      if (accept) begin
        acc_addr_h <= US_ADDR_IN;
        acc_len_h  <= US_BURST_IN;
      end
      if (q.pop) begin
        sent_h <= '0;
      end else if (beat_ok && keep) begin
        sent_h <= (BURST_W + 1)'(sent_h + 1'b1);
      end
    end
  end

  assign acc_span_h = EXP_W'(acc_addr_h[LEAD_W-1:0]) + EXP_W'(acc_len_h);

  a_base_aligned: assert property (DS_READ_OUT |->
    DS_ADDR_OUT == (acc_addr_h & ADDR_MASK) && DS_ADDR_OUT[LEAD_W-1:0] == '0)
    else $error("downstream base not rounded down to slave word");

  a_aligned_kept: assert property (DS_READ_OUT && acc_addr_h[LEAD_W-1:0] == '0 |->
    DS_ADDR_OUT == acc_addr_h)
    else $error("aligned base address was altered");

  a_len_kept: assert property (DS_READ_OUT && (acc_span_h & LEN_ROUND) == '0 |->
    DS_BURST_OUT == acc_span_h)
    else $error("burst already ending on slave word was changed");

  a_len_grown: assert property (DS_READ_OUT && (acc_span_h & LEN_ROUND) != '0 |->
    DS_BURST_OUT > acc_span_h && DS_BURST_OUT - acc_span_h < EXP_W'(RATIO))
    else $error("burst not extended to the slave word end");

  a_cmd_held: assert property (DS_READ_OUT && DS_WAIT_IN |=>
    DS_READ_OUT && $stable(DS_ADDR_OUT) && $stable(DS_BURST_OUT))
    else $error("downstream command changed while stalled");

  a_record_issue: assert property (issue_done |=> !q.empty)
    else $error("issued command left no record");

  a_drop_unasked: assert property (US_RVALID_OUT |-> $past(DS_RVALID_IN))
    else $error("upstream word without a downstream beat");

  a_word_count: assert property (q.pop |->
    (BURST_W + 1)'(sent_h + (BURST_W + 1)'(keep)) == (BURST_W + 1)'(q.head_len))
    else $error("command delivered a wrong number of words");

  a_example_10: assert property (accept && RATIO == 2 && US_ADDR_IN[0] &&
    US_BURST_IN == BURST_W'(8) |-> ##[1:2] (DS_READ_OUT && DS_BURST_OUT == EXP_W'(10)))
    else $error("misaligned 8-word read did not become a 10-word burst");

  a_full_waits: assert property (q.count == CNT_W'(MAX_PEND) |-> US_WAIT_OUT)
    else $error("master not held off with the queue full");

  // a sequence cannot sit inside a conditional, so the stage count is folded into levels
  a_issue_delay: assert property (accept |->
    !DS_READ_OUT ##1 (DS_READ_OUT == !PIPE_CMD) ##1 (DS_READ_OUT || !PIPE_CMD))
    else $error("command issue latency wrong for the pipeline setting");

endmodule // unaligned_read_burst_expander

// file: tb/wide_slave_model.sv
// Purpose : behavioural wide slave behind the burst expander
// Assumes : narrow-word beats, answers strictly in command order
// Notes   : slow_in adds random waitrequest and gaps between beats
`timescale 1ns/1ps
module wide_slave_model #(
  parameter int         AW   = 24,
  parameter int         DW   = 32,
  parameter int         EW   = 5,
  parameter logic [7:0] TAG  = 8'hC3,
  parameter int         SEED = 96
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          slow_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [EW-1:0] burst_in,
  input  wire logic          read_in,
  output logic               wait_out,
  output logic [DW-1:0]      rdata_out,
  output logic               rvalid_out
);
  logic [AW+EW-1:0] cmd_q [$];
  logic [EW-1:0]    beat_r;
  logic [AW-1:0]    base;
  int               seed_r = SEED;

  // ------------------------------------------------------------
  // command accept and in-order response
  // ------------------------------------------------------------
  // one process keeps accept and answer consistent in the same edge
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_q.delete();
      beat_r     <= '0;
      wait_out   <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out  <= '1;
    end else begin
      if (cmd_q.size() != 0 && (!slow_in || $random(seed_r) % 3 != 0)) begin
        base = cmd_q[0][AW+EW-1:EW];
        rvalid_out <= 1'b1;
        rdata_out  <= {TAG, base + AW'(beat_r)};
        if (beat_r + 1'b1 == cmd_q[0][EW-1:0]) begin
          beat_r <= '0;
          void'(cmd_q.pop_front());
        end else begin
          beat_r <= beat_r + 1'b1;
        end
      end else begin
        rvalid_out <= 1'b0;
        rdata_out  <= ~rdata_out; // idle bus must not echo the last word
      end
      if (read_in && !wait_out) cmd_q.push_back({addr_in, burst_in});
      wait_out <= slow_in && ($random(seed_r) % 2 == 0);
    end
  end
endmodule // wide_slave_model

// file: tb/tb.sv
// Purpose : self-checking bench for the unaligned read burst expander
// Assumes : 32-bit master over 64-bit slave, shallow pending queue
// Notes   : data words carry their own narrow address for checking
`timescale 1ns/1ps
module tb;
  import burst_align_pkg::*;
  localparam int         AW   = 24;
  localparam int         DW   = 32;
  localparam int         BW   = 4;
  localparam int         EW   = 5;
  localparam logic [7:0] TAG  = 8'hC3;
  localparam logic [AW-1:0] DIR_A [8] = '{24'h00_0001, 24'h00_0004, 24'h00_0002,
    24'h00_0003, 24'h00_0000, 24'h00_0005, 24'hFF_FFFF, 24'h00_0006};
  localparam logic [BW-1:0] DIR_L [8] = '{4'h8, 4'h4, 4'h3, 4'h1, 4'h1, 4'hF, 4'h1, 4'h2};

  logic          clk, rst, slow;
  logic [AW-1:0] us_addr, ds_addr;
  logic [BW-1:0] us_burst, rl;
  logic          us_read, us_wait, us_rvalid, ds_read, ds_wait, ds_rvalid;
  logic [DW-1:0] us_rdata, ds_rdata;
  logic [EW-1:0] ds_burst;
  logic [AW+EW-1:0] exp_cmd_q [$];
  logic [DW-1:0]    exp_word_q [$];
  int            num_errors, cmp_count, seed, n;

  unaligned_read_burst_expander #(.MAX_PEND(4)) uut (
    .CLK_IN(clk), .RST_IN(rst), .US_ADDR_IN(us_addr), .US_BURST_IN(us_burst),
    .US_READ_IN(us_read), .US_WAIT_OUT(us_wait), .US_RDATA_OUT(us_rdata),
    .US_RVALID_OUT(us_rvalid), .DS_ADDR_OUT(ds_addr), .DS_BURST_OUT(ds_burst),
    .DS_READ_OUT(ds_read), .DS_WAIT_IN(ds_wait), .DS_RDATA_IN(ds_rdata),
    .DS_RVALID_IN(ds_rvalid));

  wide_slave_model #(.AW(AW), .DW(DW), .EW(EW), .TAG(TAG)) slave (
    .clk_in(clk), .rst_in(rst), .slow_in(slow), .addr_in(ds_addr),
    .burst_in(ds_burst), .read_in(ds_read), .wait_out(ds_wait),
    .rdata_out(ds_rdata), .rvalid_out(ds_rvalid));

  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // reporting and compare tasks
  // ------------------------------------------------------------
  task automatic err(input string msg);
    num_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) err(msg);
  endtask

  task automatic chk_cmd(input logic [AW+EW-1:0] got);
    cmp_count++;
    if (exp_cmd_q.size() == 0) err("slave command with none expected");
    else if (got !== exp_cmd_q.pop_front()) err("slave command differs");
  endtask

  task automatic chk_word(input logic [DW-1:0] got);
    cmp_count++;
    if (exp_word_q.size() == 0) err("read word with none expected");
    else if (got !== exp_word_q.pop_front()) err("read word differs");
  endtask

  // master request: held until an edge sees waitrequest low, then noted
  task automatic issue(input logic [AW-1:0] a, input logic [BW-1:0] l);
    logic [AW-1:0] base;
    logic [AW-1:0] last;
    int            k;
    us_read  <= 1'b1;
    us_addr  <= a;
    us_burst <= l;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (us_wait !== 1'b0 && k < 300);
    if (k >= 300) err("request never taken");
    base = {a[AW-1:1], 1'b0};
    last = a + AW'(l) - 1'b1;
    exp_cmd_q.push_back({base, EW'({last[AW-1:1], 1'b1} - base + 1'b1)});
    for (int i = 0; i < l; i++) exp_word_q.push_back({TAG, a + AW'(i)});
  endtask

  // ------------------------------------------------------------
  // output watcher: oldest note against each observed result
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst && ds_read === 1'b1 && ds_wait === 1'b0) begin
      chk_cmd({ds_addr, ds_burst});
    end
    if (!rst && us_rvalid === 1'b1) begin
      chk_word(us_rdata);
    end
  end

  // watchdog, far beyond the expected few thousand cycles
  initial begin
    #500_000;
    err("watchdog expired");
    close_out();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    us_read = 1'b0;
    us_addr = '0;
    us_burst = '0;
    seed = 96;
    num_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    #1;
    chk_bit(us_wait, 1'b1, "wait low in reset");
    chk_bit(us_rvalid, 1'b0, "valid high in reset");
    chk_bit(ds_read, 1'b0, "slave read high in reset");
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // aligned, unaligned, short, long and top-of-space bursts, back to back
    for (int i = 0; i < 8; i++) begin
      issue(DIR_A[i], DIR_L[i]);
    end
    // random bursts against a stalling slave fill the pending queue
    slow <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      rl = BW'($random(seed));
      if (rl == 0) rl = 1;
      issue(AW'($random(seed)) >> 1, rl);
    end
    us_read <= 1'b0;
    n = 0;
    while ((exp_word_q.size() != 0 || exp_cmd_q.size() != 0) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
    chk_bit(exp_word_q.size() == 0, 1'b1, "read words missing");
    close_out();
  end
endmodule // tb
